// >>> inc/fifo18_pkg.sv
// Package for the 18-bit dual-clock FIFO: word type, flag carriers,
// depth choices, flag offsets and reset values.
// Assumes each clock domain has its own reset copy.
package fifo18_pkg;

  localparam int unsigned WORD_W = 18;

  typedef logic [WORD_W-1:0] word_t;

  // Legal storage depths
  localparam int unsigned DEPTH_64  = 64;
  localparam int unsigned DEPTH_256 = 256;
  localparam int unsigned DEPTH_512 = 512;
  localparam int unsigned DEPTH_1K  = 1024;
  localparam int unsigned DEPTH_2K  = 2048;
  localparam int unsigned DEPTH_4K  = 4096;

  // Fixed almost-empty / almost-full offsets, in words
  localparam int unsigned AE_OFFSET = 7;
  localparam int unsigned AF_OFFSET = 7;

  // Synchroniser stages
  localparam int unsigned SYNC_STAGES = 2;

  // Active-low flag levels after reset
  localparam logic EMPTY_RST_N    = 1'b0;
  localparam logic FULL_RST_N     = 1'b1;
  localparam logic HALF_RST_N     = 1'b1;
  localparam logic AEMPTY_RST_N   = 1'b0;
  localparam logic AFULL_RST_N    = 1'b1;

  // Read-side flags, active low
  typedef struct packed {
    logic empty_n;
    logic almost_empty_n;
  } rd_flags_t;

  // Write-side flags, active low
  typedef struct packed {
    logic full_n;
    logic almost_full_n;
    logic half_n;
  } wr_flags_t;

endpackage

// >>> src/sync_bus.sv
// Multi-bit two-flop synchroniser.
// Assumes the bus is gray coded or a single level, so that at most one
// bit moves per source edge.
`timescale 1ns/1ps
module sync_bus
  import fifo18_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Destination clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Crossing data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= din;
      stable_q <= meta_q;
    end
  end

  assign dout = stable_q;

endmodule // sync_bus

// >>> src/fifo18_dc.sv
// Dual-clock 18-bit FIFO with empty, full, half, almost flags and depth
// cascade tokens. Write side runs on clk, read side on rd_clk.
// Assumes enables and data are synchronous to their own clock.
//
// Notes on behaviour
// - Words are 18 bits wide on both the write and read ports.
// - A write-clock edge with write enable stores the input word.
// - Write enable held high stores one new word every write cycle.
// - Read port delivers words on read-clock edges with read enable.
// - Works with one shared clock or two unrelated clocks.
// - Reads and writes proceed simultaneously, each in its own domain.
// - Depth is a build parameter: 64, 256, 512, 1K, 2K or 4K words.
// - Five status outputs encode empty, almost empty, half, almost full, full.
// - Half-level output carries the write token when depth expansion is on.
// - Empty flag changes only on read-clock edges.
// - Full flag changes only on write-clock edges.
// - Empty and full are registered, glitch-free from cycle to cycle.
// - Almost flags registered when sync select low, else combinational.
// - Writes while full are ignored.
// - Reads while empty are ignored.
// - In sync flag mode almost-empty updates on read-clock edges.
// - In sync flag mode almost-full updates on write-clock edges.
`timescale 1ns/1ps
module fifo18_dc
  import fifo18_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_4K
) (
  // Write domain
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic wr_en,
  input  wire word_t wr_data,
  // Read domain
  input  wire logic rd_clk,
  input  wire logic rd_en,
  input  wire logic output_enable,
  output word_t      rd_data,
  output logic       rd_data_oe,
  // Status, active low
  output logic       empty_flag,
  output logic       almost_empty_flag,
  output logic       full_flag,
  output logic       almost_full_flag,
  output logic       half_level_flag,
  // Configuration straps
  input  wire logic flag_sync_select,
  input  wire logic depth_expand,
  input  wire logic first_device_sel,
  // Cascade tokens, one-cycle high pulses
  input  wire logic cascade_wr_token_in,
  input  wire logic cascade_rd_token_in,
  output logic       cascade_rd_token_out
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P   = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P    = PW'(DEPTH / 2);
  localparam logic [PW-1:0] AE_P      = PW'(AE_OFFSET);
  localparam logic [PW-1:0] AF_P      = PW'(DEPTH - AF_OFFSET);

  typedef logic [PW-1:0] ptr_t;

  function automatic ptr_t bin2gray(input ptr_t b);
    return b ^ (b >> 1);
  endfunction

  function automatic ptr_t gray2bin(input ptr_t g);
    ptr_t b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction

  // Storage, flip-flops indexed by address
  word_t mem_q [DEPTH];

  // Reset release, one copy per domain
  logic wrst_meta_q, wrst_n_q;
  logic rrst_meta_q, rrst_n_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrst_meta_q <= 1'b0;
      wrst_n_q    <= 1'b0;
    end else begin
      wrst_meta_q <= 1'b1;
      wrst_n_q    <= wrst_meta_q;
    end
  end

  always_ff @(posedge rd_clk or negedge reset_n) begin
    if (!reset_n) begin
      rrst_meta_q <= 1'b0;
      rrst_n_q    <= 1'b0;
    end else begin
      rrst_meta_q <= 1'b1;
      rrst_n_q    <= rrst_meta_q;
    end
  end

  // Write domain state
  ptr_t      wr_bin_q, wr_gray_q, rd_gray_w, rd_bin_w;
  wr_flags_t wflags_q;
  logic      wr_token_q, wr_started_q, wr_token_pulse_q;
  logic      wr_fire;
  ptr_t      wr_bin_d, wcount_now, wcount_d;

  // Read domain state
  ptr_t      rd_bin_q, rd_gray_q, wr_gray_r, wr_bin_r;
  rd_flags_t rflags_q;
  logic      rd_token_q, rd_started_q, rd_token_pulse_q;
  logic      rd_fire;
  ptr_t      rd_bin_d, rcount_now, rcount_d;
  word_t     rd_data_q;
  word_t     rd_pin_q;
  logic      rd_oe_q;

  // Gray pointers cross between the free-running clocks
  sync_bus #(.WIDTH(PW)) u_rd_to_w (
    .clk   (clk),
    .rst_n (wrst_n_q),
    .din   (rd_gray_q),
    .dout  (rd_gray_w)
  );

  sync_bus #(.WIDTH(PW)) u_wr_to_r (
    .clk   (rd_clk),
    .rst_n (rrst_n_q),
    .din   (wr_gray_q),
    .dout  (wr_gray_r)
  );

  assign rd_bin_w = gray2bin(rd_gray_w);
  assign wr_bin_r = gray2bin(wr_gray_r);

  // Write side: full flag gates storage, token gates in a cascade
  assign wr_fire    = wr_en && wflags_q.full_n &&
                      (!depth_expand || wr_token_q);
  assign wr_bin_d   = wr_fire ? wr_bin_q + 1'b1 : wr_bin_q;
  assign wcount_now = wr_bin_q - rd_bin_w;
  assign wcount_d   = wr_bin_d - rd_bin_w;

  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem_q[wr_bin_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge wrst_n_q) begin
    if (!wrst_n_q) begin
      wr_bin_q  <= '0;
      wr_gray_q <= '0;
    end else begin
      wr_bin_q  <= wr_bin_d;
      wr_gray_q <= bin2gray(wr_bin_d);
    end
  end

  // Flags use the next pointer so they never lag a write by a cycle
  always_ff @(posedge clk or negedge wrst_n_q) begin
    if (!wrst_n_q) begin
      wflags_q.full_n        <= FULL_RST_N;
      wflags_q.almost_full_n <= AFULL_RST_N;
      wflags_q.half_n        <= HALF_RST_N;
    end else begin
      wflags_q.full_n        <= (wcount_d != DEPTH_P);
      wflags_q.almost_full_n <= (wcount_d < AF_P);
      wflags_q.half_n        <= !(wcount_d > HALF_P);
    end
  end

  // Write token: strap caught on the first cycle after release
  always_ff @(posedge clk or negedge wrst_n_q) begin
    if (!wrst_n_q) begin
      wr_started_q     <= 1'b0;
      wr_token_q       <= 1'b0;
      wr_token_pulse_q <= 1'b0;
    end else begin
      wr_started_q     <= 1'b1;
      wr_token_pulse_q <= 1'b0;
      if (!wr_started_q) begin
        wr_token_q <= !first_device_sel;
      end else if (depth_expand && wr_token_q && wr_fire && wcount_d == DEPTH_P) begin
        wr_token_q       <= 1'b0;
        wr_token_pulse_q <= 1'b1;
      end else if (cascade_wr_token_in) begin
        wr_token_q <= 1'b1;
      end
    end
  end

  // Read side
  assign rd_fire    = rd_en && rflags_q.empty_n &&
                      (!depth_expand || rd_token_q);
  assign rd_bin_d   = rd_fire ? rd_bin_q + 1'b1 : rd_bin_q;
  assign rcount_now = wr_bin_r - rd_bin_q;
  assign rcount_d   = wr_bin_r - rd_bin_d;

  always_ff @(posedge rd_clk or negedge rrst_n_q) begin
    if (!rrst_n_q) begin
      rd_bin_q  <= '0;
      rd_gray_q <= '0;
    end else begin
      rd_bin_q  <= rd_bin_d;
      rd_gray_q <= bin2gray(rd_bin_d);
    end
  end

  always_ff @(posedge rd_clk or negedge rrst_n_q) begin
    if (!rrst_n_q) begin
      rd_data_q <= '0;
    end else if (rd_fire) begin
      rd_data_q <= mem_q[rd_bin_q[AW-1:0]];
    end
  end

  // Output enable only masks the pins; pointers keep moving
  always_ff @(posedge rd_clk or negedge rrst_n_q) begin
    if (!rrst_n_q) begin
      rd_oe_q <= 1'b0;
    end else begin
      rd_oe_q <= output_enable;
    end
  end

  // Pin copy is its own flop so the data output comes straight from a register
  always_ff @(posedge rd_clk or negedge rrst_n_q) begin
    if (!rrst_n_q) begin
      rd_pin_q <= '0;
    end else if (!output_enable) begin
      rd_pin_q <= '0;
    end else if (rd_fire) begin
      rd_pin_q <= mem_q[rd_bin_q[AW-1:0]];
    end else begin
      rd_pin_q <= rd_data_q;
    end
  end

  always_ff @(posedge rd_clk or negedge rrst_n_q) begin
    if (!rrst_n_q) begin
      rflags_q.empty_n        <= EMPTY_RST_N;
      rflags_q.almost_empty_n <= AEMPTY_RST_N;
    end else begin
      rflags_q.empty_n        <= (rcount_d != '0);
      rflags_q.almost_empty_n <= (rcount_d > AE_P);
    end
  end

  // Read token passes when this device drains its last word
  always_ff @(posedge rd_clk or negedge rrst_n_q) begin
    if (!rrst_n_q) begin
      rd_started_q     <= 1'b0;
      rd_token_q       <= 1'b0;
      rd_token_pulse_q <= 1'b0;
    end else begin
      rd_started_q     <= 1'b1;
      rd_token_pulse_q <= 1'b0;
      if (!rd_started_q) begin
        rd_token_q <= !first_device_sel;
      end else if (depth_expand && rd_token_q && rd_fire && rcount_d == '0) begin
        rd_token_q       <= 1'b0;
        rd_token_pulse_q <= 1'b1;
      end else if (cascade_rd_token_in) begin
        rd_token_q <= 1'b1;
      end
    end
  end

  // Outputs
  assign rd_data    = rd_pin_q;
  assign rd_data_oe = rd_oe_q;
  assign empty_flag = rflags_q.empty_n;
  assign full_flag  = wflags_q.full_n;
  assign cascade_rd_token_out = rd_token_pulse_q;

  // Shared pin: half level standalone, write token when cascaded
  assign half_level_flag = depth_expand ? wr_token_pulse_q
                                        : wflags_q.half_n;

  // Combinational mode trades glitch-freedom for zero latency
  assign almost_empty_flag = flag_sync_select ? (rcount_now > AE_P)
                                              : rflags_q.almost_empty_n;
  assign almost_full_flag  = flag_sync_select ? (wcount_now < AF_P)
                                              : wflags_q.almost_full_n;

endmodule // fifo18_dc

// >>> testbench/fifo18_reader.sv
// Reader-side partner model: pulls words while told to, stalls on request.
// Assumes rd_data shows the word right after the edge that took the read.
`timescale 1ns/1ps
module fifo18_reader
  import fifo18_pkg::*;
(
  // Read domain
  input  wire logic  rd_clk,
  input  wire logic  rst_n,
  // Bench control
  input  wire logic  go,
  input  wire logic  slow,
  // FIFO read port
  input  wire logic  empty_flag,
  input  wire word_t rd_data,
  output logic       rd_en,
  output logic       got_valid,
  output word_t      got_word
);
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_en     <= 1'b0;
      got_valid <= 1'b0;
    end else begin
      // Slow mode drops enable every other cycle to stall the reader
      rd_en     <= go && !(slow && rd_en);
      got_valid <= rd_en && empty_flag;
    end
  end
  assign got_word = rd_data;
endmodule // fifo18_reader

// >>> testbench/fifo18_dc_asserts.sv
// Port checker for the FIFO top, bound into every instance.
// Assumes read and write clocks are tied together, as in the bench.
`timescale 1ns/1ps
module fifo18_dc_checker
  import fifo18_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_4K
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  reset_n,
  // Watched ports
  input wire logic  wr_en,
  input wire logic  rd_en,
  input wire logic  output_enable,
  input wire word_t rd_data,
  input wire logic  rd_data_oe,
  input wire logic  empty_flag,
  input wire logic  almost_empty_flag,
  input wire logic  full_flag,
  input wire logic  almost_full_flag,
  input wire logic  half_level_flag,
  input wire logic  depth_expand
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_full_cause: assert property ($fell(full_flag) |-> $past(wr_en))
    else $error("full asserted without a write");
  // Six idle read cycles cover the pointer sync lag
  a_full_holds: assert property ((!rd_en)[*6] ##0 !full_flag |=> !full_flag)
    else $error("full cleared without a read");
  a_empty_cause: assert property ($fell(empty_flag) |-> $past(rd_en && empty_flag))
    else $error("empty asserted without a read");
  a_empty_aempty: assert property (!empty_flag |-> !almost_empty_flag)
    else $error("empty without almost empty");
  a_full_afull: assert property (!full_flag |-> !almost_full_flag)
    else $error("full without almost full");
  a_afull_half: assert property (!almost_full_flag && !depth_expand |-> !half_level_flag)
    else $error("almost full without half");
  a_oe_release: assert property (!output_enable |=> !rd_data_oe && rd_data == '0)
    else $error("read data still driven");
  a_data_holds: assert property (rd_data_oe && output_enable && !(rd_en && empty_flag)
    |=> $stable(rd_data))
    else $error("read data moved without a read");
  cover property ($fell(full_flag));
  cover property ($rose(empty_flag));
  cover property ($fell(rd_data_oe));
endmodule // fifo18_dc_checker

bind fifo18_dc fifo18_dc_checker #(.DEPTH(DEPTH)) u_chk (
  .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
  .output_enable(output_enable), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
  .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag),
  .full_flag(full_flag), .almost_full_flag(almost_full_flag),
  .half_level_flag(half_level_flag), .depth_expand(depth_expand));

// >>> testbench/tb_fifo18_dc.sv
// Self-checking bench: fill past full, drain, overlap, output release.
// Assumes one shared clock for both ports and a 64-word build.
`timescale 1ns/1ps
module tb_fifo18_dc;
  import fifo18_pkg::*;
  localparam int unsigned DEPTH = DEPTH_64;
  logic  clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, output_enable = 1'b1;
  logic  go = 1'b0, slow = 1'b0, fsync = 1'b0;
  word_t wr_data = '0;
  logic  rd_en, rd_data_oe, empty_flag, almost_empty_flag, full_flag;
  logic  almost_full_flag, half_level_flag, got_valid;
  word_t rd_data, got_word;
  int    error_cnt = 0, cmp_count = 0, rd_idx = 0, wseq = 0, wcount = 0;

  always #20 clk = ~clk;

  fifo18_dc #(.DEPTH(DEPTH)) i_dut (
    .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .wr_data(wr_data),
    .rd_clk(clk), .rd_en(rd_en), .output_enable(output_enable),
    .rd_data(rd_data), .rd_data_oe(rd_data_oe), .empty_flag(empty_flag),
    .almost_empty_flag(almost_empty_flag), .full_flag(full_flag),
    .almost_full_flag(almost_full_flag), .half_level_flag(half_level_flag),
    // Standalone strapping: no ring, first-device select low
    .flag_sync_select(fsync), .depth_expand(1'b0), .first_device_sel(1'b0),
    .cascade_wr_token_in(1'b0), .cascade_rd_token_in(1'b0),
    .cascade_rd_token_out());

  fifo18_reader i_rdr (
    .rd_clk(clk), .rst_n(reset_n), .go(go), .slow(slow), .empty_flag(empty_flag),
    .rd_data(rd_data), .rd_en(rd_en), .got_valid(got_valid), .got_word(got_word));

  function automatic word_t pat(input int n);
    return word_t'(18'h15a5a ^ (n << 3));
  endfunction

  task automatic check_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic check_word(input word_t got, input word_t exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  // Flags seen just after an edge still carry the previous edge's update
  task automatic write_burst(input int n, input bit chk);
    wr_en <= 1'b1;
    for (int i = 0; i <= n; i++) begin
      if (i < n) wr_data <= pat(wseq);
      else wr_en <= 1'b0;
      @(posedge clk);
      if (chk) begin
        check_bit(full_flag, wcount < DEPTH, "full flag");
        check_bit(almost_full_flag, wcount < DEPTH - AF_OFFSET, "almost full");
        check_bit(half_level_flag, wcount <= DEPTH / 2, "half flag");
      end
      if (i < n && wcount < DEPTH) begin
        wseq++;
        wcount++;
      end
    end
  endtask

  task automatic wait_reads(input int target);
    for (int i = 0; i < 1000 && rd_idx < target; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    check_bit(rd_idx == target, 1'b1, "read count");
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (got_valid === 1'b1) begin
      check_word(got_word, pat(rd_idx), "read word");
      rd_idx++;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    check_bit(empty_flag, 1'b0, "reset empty");
    check_bit(full_flag, 1'b1, "reset full");
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check_bit(rd_data_oe, 1'b1, "data driven");
    write_burst(DEPTH + 2, 1'b1);
    check_bit(empty_flag, 1'b1, "not empty");
    check_bit(almost_empty_flag, 1'b1, "not almost empty");
    go   <= 1'b1;
    slow <= 1'b1;
    wait_reads(DEPTH);
    check_bit(empty_flag, 1'b0, "drained empty");
    check_bit(almost_empty_flag, 1'b0, "drained almost empty");
    check_bit(full_flag, 1'b1, "full released");
    wcount = 0;
    slow <= 1'b0;
    write_burst(20, 1'b0);
    wait_reads(DEPTH + 20);
    output_enable <= 1'b0;
    repeat (3) @(posedge clk);
    check_bit(rd_data_oe, 1'b0, "released");
    check_word(rd_data, '0, "released data");
    output_enable <= 1'b1;
    repeat (3) @(posedge clk);
    check_word(rd_data, pat(DEPTH + 19), "data kept");
    // Combinational almost flags on an empty buffer
    fsync <= 1'b1;
    @(posedge clk);
    #1;
    check_bit(almost_empty_flag, 1'b0, "comb almost empty");
    check_bit(almost_full_flag, 1'b1, "comb almost full");
    results();
  end

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // tb_fifo18_dc
